// File: core/dlc_top.sv
// lock detectors, tuning word clamp/history and loop state machine with AXI4-Lite registers
// Summary of operation
// R1 - bucket level saturates between -2048 empty and +2048 full, never wraps
// R2 - fill and drain amounts are separate 8-bit per-profile rates
// R3 - level below -1024 reports unlocked
// R4 - level above +1024 reports locked
// R5 - level between marks keeps previous lock indication
// R6 - each sample while the loop stays closed causes exactly one update, fill or drain
// R7 - phase threshold is 24-bit per-profile picoseconds against error magnitude
// R8 - magnitude at most threshold fills, else drains; sign ignored
// R9 - free run or holdover forces both detectors unlocked
// R10 - lock state is preserved through a reference switchover
// R11 - frequency detector reuses bucket mechanism on period difference
// R12 - frequency threshold is 24-bit picoseconds against period difference magnitude
// R13 - tuning word is clamped to programmed minimum and maximum
// R14 - tuning word samples are averaged over programmed interval for holdover
// R15 - switchover passes briefly through the switch state, loads new profile, recloses loop
// R16 - holdover, automatic or by user, holds tuning word constant
// R17 - valid reference in holdover recloses loop, profile loaded in sequence
// R18 - user holdover bit blocks automatic exit until cleared
// R19 - control bits force holdover or free run; free run uses programmed word
// R20 - reset empties both buckets and clears both lock indications
module dlc_top
	import dlc_pkg::*;
#(
	parameter int HIST_CNT_W = 16
)
(
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic SRST_I,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// detector samples and loop filter word
	input wire logic PH_VALID_I,
	input wire logic [31:0] PH_ERR_I,
	input wire logic FR_VALID_I,
	input wire logic [31:0] FR_DIFF_I,
	input wire logic LF_VALID_I,
	input wire logic [TW_W-1:0] LF_TW_I,
	// reference selection
	input wire logic [NREF-1:0] REF_VALID_I,
	input wire logic [REF_W-1:0] REF_SEL_I,
	// loop outputs
	output logic [TW_W-1:0] TW_O,
	output logic PH_LOCK_O,
	output logic FR_LOCK_O,
	output logic [4:0] LOOP_STATE_O,
	output logic [REF_W-1:0] ACT_REF_O
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_have_q, w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [31:0] ctrl_q, freerun_q, tw_min_q, tw_max_q;
	dlc_prof_s prof_q [NREF];
	dlc_prof_s act_prof_q;
	logic [REF_W-1:0] act_ref_q;
	dlc_state_e st_q, st_d;
	logic [1:0] rec_step_q;
	logic [TW_W-1:0] tw_q, tw_d, tw_src;
	logic [TW_W-1:0] hist_q;
	logic hist_vld_q;
	logic [TW_W+HIST_CNT_W-1:0] hist_sum_q;
	logic [HIST_CNT_W-1:0] hist_cnt_q;
	logic signed [LVL_W-1:0] lvl_q [2];
	logic [1:0] lock_q;
	logic [31:0] rd_word, wr_old;

	// ------------------------------------------------------------
	// register readback
	// ------------------------------------------------------------
	function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a);
		logic [31:0] w;
		dlc_prof_s p;
		logic [ADDR_W-1:0] aw;
		aw = {a[ADDR_W-1:2], 2'b00};
		p = prof_q[a[PROF_IDX_LSB+:REF_W]];
		w = 32'h0;
		if (aw[ADDR_W-1:6] == OFS_PROF_BASE[ADDR_W-1:6])
		begin
			case (aw[3:2])
				FLD_PH_THR: w = {8'h0, p.ph_thr};
				FLD_FR_THR: w = {8'h0, p.fr_thr};
				FLD_RATES: w = {p.fr_drain, p.fr_fill, p.ph_drain, p.ph_fill};
				default: w = 32'h0;
			endcase
		end
		else
		begin
			case (aw)
				OFS_CTRL: w = ctrl_q;
				OFS_STATUS: w = {21'h0, hist_vld_q, act_ref_q, 1'b0, st_q, lock_q};
				OFS_FREERUN_TW: w = freerun_q;
				OFS_TW_MIN: w = tw_min_q;
				OFS_TW_MAX: w = tw_max_q;
				OFS_HOLD_TW: w = hist_q;
				OFS_LEVEL: w = {{3{lvl_q[1][LVL_W-1]}}, lvl_q[1], {3{lvl_q[0][LVL_W-1]}}, lvl_q[0]};
				default: w = 32'h0;
			endcase
		end
		return w;
	endfunction

	// function reads module state, so always_comb keeps it sensitive to that state
	always_comb
	begin
		rd_word = reg_word(S_AXI_ARADDR_I);
		wr_old = reg_word(awaddr_q);
	end

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	wire aw_take = S_AXI_AWVALID_I && awready_q;
	wire w_take = S_AXI_WVALID_I && wready_q;
	wire wr_go = aw_have_q && w_have_q && !bvalid_q;
	wire b_done = bvalid_q && S_AXI_BREADY_I;
	wire ar_take = S_AXI_ARVALID_I && arready_q;
	wire r_done = rvalid_q && S_AXI_RREADY_I;
	wire wr_ok = dlc_addr_ok(awaddr_q);
	wire [31:0] wr_word = dlc_merge(wr_old, wdata_q, wstrb_q);
	wire [ADDR_W-1:0] wa = {awaddr_q[ADDR_W-1:2], 2'b00};
	wire wa_prof = wa[ADDR_W-1:6] == OFS_PROF_BASE[ADDR_W-1:6];
	wire [REF_W-1:0] wa_idx = wa[PROF_IDX_LSB+:REF_W];

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (aw_take)
			begin
				awaddr_q <= S_AXI_AWADDR_I;
				aw_have_q <= 1'b1;
				awready_q <= 1'b0;
			end
			if (w_take)
			begin
				wdata_q <= S_AXI_WDATA_I;
				wstrb_q <= S_AXI_WSTRB_I;
				w_have_q <= 1'b1;
				wready_q <= 1'b0;
			end
			if (wr_go)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (b_done)
			begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end
		else if (ar_take)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= dlc_addr_ok(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (r_done)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// software registers; status, held word and level are read only
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
		begin
			ctrl_q <= CTRL_RST;
			freerun_q <= FREERUN_TW_RST;
			tw_min_q <= TW_MIN_RST;
			tw_max_q <= TW_MAX_RST;
		end
		else if (wr_go && !wa_prof)
		begin
			if (wa == OFS_CTRL)
				ctrl_q <= wr_word & CTRL_MASK;
			if (wa == OFS_FREERUN_TW)
				freerun_q <= wr_word;
			if (wa == OFS_TW_MIN)
				tw_min_q <= wr_word;
			if (wa == OFS_TW_MAX)
				tw_max_q <= wr_word;
		end
	end

	// per-reference profiles: thresholds and fill/drain rates
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
		begin
			for (int i = 0; i < NREF; i++)
				prof_q[i] <= PROF_RST;
		end
		else if (wr_go && wa_prof)
		begin
			case (wa[3:2])
				FLD_PH_THR: prof_q[wa_idx].ph_thr <= wr_word[23:0]; // [R7]
				FLD_FR_THR: prof_q[wa_idx].fr_thr <= wr_word[23:0]; // [R12]
				FLD_RATES: {prof_q[wa_idx].fr_drain, prof_q[wa_idx].fr_fill,
					prof_q[wa_idx].ph_drain, prof_q[wa_idx].ph_fill} <= wr_word; // [R2]
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// loop state machine
	// ------------------------------------------------------------
	wire u_hold = ctrl_q[CTRL_UHOLD_BIT];
	wire u_free = ctrl_q[CTRL_UFREE_BIT];
	wire ref_ok = REF_VALID_I[REF_SEL_I];
	wire leave_closed = u_hold || !ref_ok;

	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ST_FREE:
				if (!u_free)
					st_d = leave_closed ? ST_HOLD : ST_RECOV; // [R19]
			ST_HOLD:
				if (u_free)
					st_d = ST_FREE;
				else if (!u_hold && ref_ok)
					st_d = ST_RECOV; // [R17] [R18]
			ST_RECOV:
				if (u_free)
					st_d = ST_FREE;
				else if (leave_closed)
					st_d = ST_HOLD;
				else if (rec_step_q == REC_LAST)
					st_d = ST_CLOSED; // [R17]
			ST_SWITCH:
				if (u_free)
					st_d = ST_FREE;
				else if (leave_closed)
					st_d = ST_HOLD;
				else
					st_d = ST_CLOSED; // [R15]
			ST_CLOSED:
				if (u_free)
					st_d = ST_FREE; // [R19]
				else if (leave_closed)
					st_d = ST_HOLD; // [R16]
				else if (REF_SEL_I != act_ref_q)
					st_d = ST_SWITCH; // [R15]
			default: st_d = ST_FREE;
		endcase
	end

	// recovery loads phase settings first, then frequency settings
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
		begin
			st_q <= ST_FREE;
			rec_step_q <= 2'h0;
			act_ref_q <= '0;
			act_prof_q <= PROF_RST;
		end
		else
		begin
			st_q <= st_d;
			rec_step_q <= (st_q == ST_RECOV) ? rec_step_q + 2'h1 : 2'h0;
			if (st_q == ST_SWITCH)
			begin
				act_ref_q <= REF_SEL_I;
				act_prof_q <= prof_q[REF_SEL_I]; // [R15]
			end
			else if (st_q == ST_RECOV && rec_step_q == 2'h0)
			begin
				act_ref_q <= REF_SEL_I;
				act_prof_q.ph_thr <= prof_q[REF_SEL_I].ph_thr; // [R17]
				act_prof_q.ph_fill <= prof_q[REF_SEL_I].ph_fill;
				act_prof_q.ph_drain <= prof_q[REF_SEL_I].ph_drain;
			end
			else if (st_q == ST_RECOV && rec_step_q == 2'h1)
			begin
				act_prof_q.fr_thr <= prof_q[act_ref_q].fr_thr; // [R17]
				act_prof_q.fr_fill <= prof_q[act_ref_q].fr_fill;
				act_prof_q.fr_drain <= prof_q[act_ref_q].fr_drain;
			end
		end
	end

	// ------------------------------------------------------------
	// tuning word: clamp, hold and free run
	// ------------------------------------------------------------
	function automatic logic [TW_W-1:0] clamp_tw(input logic [TW_W-1:0] v,
		input logic [TW_W-1:0] lo, input logic [TW_W-1:0] hi);
		if (v < lo)
			return lo;
		if (v > hi)
			return hi;
		return v;
	endfunction

	wire hold_entry = (st_q != ST_HOLD) && (st_d == ST_HOLD);
	// holding skips the clamp so a limit change cannot move a held word
	wire tw_keep = (st_q != ST_FREE) && (st_q != ST_CLOSED) && !hold_entry; // [R16]
	assign tw_src = (hold_entry && hist_vld_q) ? hist_q :
		(st_q == ST_FREE) ? freerun_q : // [R19]
		(st_q == ST_CLOSED && LF_VALID_I) ? LF_TW_I : tw_q;
	assign tw_d = tw_keep ? tw_q : clamp_tw(tw_src, tw_min_q, tw_max_q); // [R13]

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
			tw_q <= FREERUN_TW_RST;
		else
			tw_q <= tw_d;
	end

	// ------------------------------------------------------------
	// tuning word history, 2**sel samples per average
	// ------------------------------------------------------------
	wire [HIST_SEL_W-1:0] hist_sel = ctrl_q[CTRL_HIST_LSB+:HIST_SEL_W];
	wire [HIST_CNT_W-1:0] hist_last = (HIST_CNT_W'(1) << hist_sel) - HIST_CNT_W'(1);
	wire hist_take = LF_VALID_I && (st_q == ST_CLOSED);
	wire [TW_W+HIST_CNT_W-1:0] hist_sum_d = hist_sum_q + (TW_W+HIST_CNT_W)'(LF_TW_I);

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
		begin
			hist_q <= '0;
			hist_vld_q <= 1'b0;
			hist_sum_q <= '0;
			hist_cnt_q <= '0;
		end
		else if (hist_take && hist_cnt_q >= hist_last)
		begin
			hist_q <= TW_W'(hist_sum_d >> hist_sel); // [R14]
			hist_vld_q <= 1'b1;
			hist_sum_q <= '0;
			hist_cnt_q <= '0;
		end
		else if (hist_take)
		begin
			hist_sum_q <= hist_sum_d;
			hist_cnt_q <= hist_cnt_q + HIST_CNT_W'(1);
		end
	end

	// ------------------------------------------------------------
	// phase (0) and frequency (1) bucket detectors
	// ------------------------------------------------------------
	// a sample on the edge into switchover would move lock inside the switch
	wire det_run = (st_q == ST_CLOSED) && (st_d == ST_CLOSED);
	wire det_clear = (st_q == ST_FREE) || (st_q == ST_HOLD);
	wire [1:0] det_vld = {FR_VALID_I, PH_VALID_I};
	wire [31:0] det_smp [2];
	wire [23:0] det_thr [2];
	wire [7:0] det_fill [2];
	wire [7:0] det_drain [2];
	wire [1:0] det_in_thr;
	assign det_smp[0] = PH_ERR_I;
	assign det_smp[1] = FR_DIFF_I; // [R11]
	assign det_thr[0] = act_prof_q.ph_thr;
	assign det_thr[1] = act_prof_q.fr_thr;
	assign det_fill[0] = act_prof_q.ph_fill;
	assign det_fill[1] = act_prof_q.fr_fill;
	assign det_drain[0] = act_prof_q.ph_drain;
	assign det_drain[1] = act_prof_q.fr_drain;

	for (genvar g = 0; g < 2; g++)
	begin : g_det
		logic [32:0] mag;
		logic signed [LVL_W:0] up, dn;
		logic signed [LVL_W-1:0] lvl_d;
		// 33 bits so the most negative sample still gets its true magnitude
		assign mag = det_smp[g][31] ? (33'h0 - {1'b1, det_smp[g]}) : {1'b0, det_smp[g]};
		assign det_in_thr[g] = mag <= {9'h0, det_thr[g]}; // [R8]
		assign up = $signed({lvl_q[g][LVL_W-1], lvl_q[g]}) + $signed({6'h0, det_fill[g]});
		assign dn = $signed({lvl_q[g][LVL_W-1], lvl_q[g]}) - $signed({6'h0, det_drain[g]});
		assign lvl_d = det_in_thr[g] ?
			((up > (LVL_W+1)'(LVL_FULL)) ? LVL_FULL : up[LVL_W-1:0]) :
			((dn < (LVL_W+1)'(LVL_EMPTY)) ? LVL_EMPTY : dn[LVL_W-1:0]); // [R1]

		always_ff @(posedge CLK_SYS_I)
		begin
			if (SRST_I || det_clear)
			begin
				lvl_q[g] <= LVL_EMPTY; // [R20]
				lock_q[g] <= 1'b0; // [R9]
			end
			else
			begin
				// frozen during switchover: lock follows an unchanged level
				if (det_run && det_vld[g])
					lvl_q[g] <= lvl_d; // [R6] [R10]
				if (lvl_q[g] > LVL_HI)
					lock_q[g] <= 1'b1; // [R4]
				else if (lvl_q[g] < LVL_LO)
					lock_q[g] <= 1'b0; // [R3] [R5]
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign S_AXI_AWREADY_O = awready_q;
	assign S_AXI_WREADY_O = wready_q;
	assign S_AXI_BVALID_O = bvalid_q;
	assign S_AXI_BRESP_O = bresp_q;
	assign S_AXI_ARREADY_O = arready_q;
	assign S_AXI_RVALID_O = rvalid_q;
	assign S_AXI_RDATA_O = rdata_q;
	assign S_AXI_RRESP_O = rresp_q;
	assign TW_O = tw_q;
	assign PH_LOCK_O = lock_q[0];
	assign FR_LOCK_O = lock_q[1];
	assign LOOP_STATE_O = st_q;
	assign ACT_REF_O = act_ref_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (SRST_I);

	property p_lvl_range;
		lvl_q[0] >= LVL_EMPTY && lvl_q[0] <= LVL_FULL && lvl_q[1] >= LVL_EMPTY && lvl_q[1] <= LVL_FULL;
	endproperty
	a_lvl_range: assert property (p_lvl_range) else $error("bucket level out of range"); // [R1]
	property p_drain;
		det_run && PH_VALID_I && !det_in_thr[0] && act_prof_q.ph_drain != 8'h0 &&
			lvl_q[0] != LVL_EMPTY |=> lvl_q[0] < $past(lvl_q[0]);
	endproperty
	a_drain: assert property (p_drain) else $error("out of threshold sample did not drain"); // [R8]
	property p_idle;
		!PH_VALID_I && !det_clear |=> $stable(lvl_q[0]);
	endproperty
	a_idle: assert property (p_idle) else $error("level moved without sample"); // [R6]
	property p_unlock;
		lvl_q[1] < LVL_LO |=> !FR_LOCK_O;
	endproperty
	a_unlock: assert property (p_unlock) else $error("low level but locked"); // [R3]
	property p_lock;
		lvl_q[0] > LVL_HI && !det_clear |=> PH_LOCK_O;
	endproperty
	a_lock: assert property (p_lock) else $error("high level but unlocked"); // [R4]
	property p_hyst;
		lvl_q[0] >= LVL_LO && lvl_q[0] <= LVL_HI && !det_clear |=> $stable(PH_LOCK_O);
	endproperty
	a_hyst: assert property (p_hyst) else $error("lock changed between marks"); // [R5]
	property p_free_unlock;
		det_clear |=> !PH_LOCK_O && !FR_LOCK_O && lvl_q[0] == LVL_EMPTY;
	endproperty
	a_free_unlock: assert property (p_free_unlock) else $error("lock shown in hold or free"); // [R9]
	property p_switch;
		st_q == ST_SWITCH |=> $stable(PH_LOCK_O) && $stable(FR_LOCK_O) && st_q != ST_SWITCH;
	endproperty
	a_switch: assert property (p_switch) else $error("switchover not brief or lock lost"); // [R10] [R15]
	property p_clamp;
		!tw_keep && tw_min_q <= tw_max_q |=> TW_O >= $past(tw_min_q) && TW_O <= $past(tw_max_q);
	endproperty
	a_clamp: assert property (p_clamp) else $error("tuning word outside limits"); // [R13]
	property p_hold_tw;
		st_q == ST_HOLD |=> $stable(TW_O);
	endproperty
	a_hold_tw: assert property (p_hold_tw) else $error("tuning word moved in holdover"); // [R16]
	property p_recov;
		st_q == ST_RECOV && !u_free && !leave_closed |-> ##[1:3] st_q == ST_CLOSED;
	endproperty
	a_recov: assert property (p_recov) else $error("recovery did not close loop"); // [R17]
	property p_user_hold;
		u_hold && st_q == ST_HOLD |=> st_q == ST_HOLD || st_q == ST_FREE;
	endproperty
	a_user_hold: assert property (p_user_hold) else $error("left user holdover"); // [R18]
	property p_freerun;
		st_q == ST_FREE && !hold_entry && freerun_q >= tw_min_q && freerun_q <= tw_max_q |=>
			TW_O == $past(freerun_q);
	endproperty
	a_freerun: assert property (p_freerun) else $error("free run word not applied"); // [R19]
	property p_reset;
		$past(SRST_I) |-> lvl_q[0] == LVL_EMPTY && lvl_q[1] == LVL_EMPTY && lock_q == 2'b00;
	endproperty
	a_reset: assert property (p_reset) else $error("reset did not empty buckets"); // [R20]
	property p_c_lock;
		st_q == ST_CLOSED && PH_LOCK_O && FR_LOCK_O;
	endproperty
	c_lock: cover property (p_c_lock);
	property p_c_switch;
		st_q == ST_SWITCH && PH_LOCK_O ##1 st_q == ST_CLOSED;
	endproperty
	c_switch: cover property (p_c_switch);
	property p_c_recover;
		st_q == ST_HOLD && hist_vld_q ##1 st_q == ST_RECOV;
	endproperty
	c_recover: cover property (p_c_recover);
endmodule

// File: core/dlc_pkg.sv
// constants, types and helpers shared by the lock detect / loop control block
package dlc_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int NREF = 4;
	localparam int REF_W = 2;
	localparam int ADDR_W = 8;
	localparam int TW_W = 32;
	localparam int LVL_W = 13;
	localparam int PROF_IDX_LSB = 4;
	// ------------------------------------------------------------
	// register offsets and fields
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FREERUN_TW = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_TW_MIN = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_TW_MAX = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_HOLD_TW = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PROF_BASE = 8'h40;
	localparam logic [1:0] FLD_PH_THR = 2'h0;
	localparam logic [1:0] FLD_FR_THR = 2'h1;
	localparam logic [1:0] FLD_RATES = 2'h2;
	localparam int CTRL_UHOLD_BIT = 0;
	localparam int CTRL_UFREE_BIT = 1;
	localparam int CTRL_HIST_LSB = 4;
	localparam int HIST_SEL_W = 4;
	localparam logic [31:0] CTRL_MASK = 32'h0000_00f3;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] FREERUN_TW_RST = 32'h0000_0000;
	localparam logic [31:0] TW_MIN_RST = 32'h0000_0000;
	localparam logic [31:0] TW_MAX_RST = 32'hffff_ffff;
	// ------------------------------------------------------------
	// bucket level marks, last recovery step and response codes
	// ------------------------------------------------------------
	localparam logic signed [LVL_W-1:0] LVL_FULL = 13'sh0800;
	localparam logic signed [LVL_W-1:0] LVL_EMPTY = -13'sh0800;
	localparam logic signed [LVL_W-1:0] LVL_HI = 13'sh0400;
	localparam logic signed [LVL_W-1:0] LVL_LO = -13'sh0400;
	localparam logic [1:0] REC_LAST = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [23:0] ph_thr;
		logic [23:0] fr_thr;
		logic [7:0] fr_drain;
		logic [7:0] fr_fill;
		logic [7:0] ph_drain;
		logic [7:0] ph_fill;
	} dlc_prof_s;
	localparam dlc_prof_s PROF_RST = '{24'h0, 24'h0, 8'h01, 8'h01, 8'h01, 8'h01};
	typedef enum logic [4:0] {
		ST_FREE = 5'b00001,
		ST_HOLD = 5'b00010,
		ST_RECOV = 5'b00100,
		ST_SWITCH = 5'b01000,
		ST_CLOSED = 5'b10000
	} dlc_state_e;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] dlc_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i+:8] = nw[8*i+:8];
		return r;
	endfunction
	function automatic logic dlc_addr_ok(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] w;
		w = {a[ADDR_W-1:2], 2'b00};
		if (w[ADDR_W-1:6] == OFS_PROF_BASE[ADDR_W-1:6])
			return w[3:2] != 2'h3;
		return (w == OFS_CTRL) || (w == OFS_STATUS) || (w == OFS_FREERUN_TW) ||
			(w == OFS_TW_MIN) || (w == OFS_TW_MAX) || (w == OFS_HOLD_TW) || (w == OFS_LEVEL);
	endfunction
endpackage

// File: test/dlc_ref_model.sv
// reference side model: phase error and period difference samples on command
module dlc_ref_model
	import dlc_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic fire_i,
	input wire logic [31:0] mag_i,
	output logic ph_valid_o,
	output logic [31:0] ph_err_o,
	output logic fr_valid_o,
	output logic [31:0] fr_diff_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sgn_q;
	logic [31:0] val_d;
	// sign alternates so a detector that looks at polarity goes wrong
	assign val_d = sgn_q ? -mag_i : mag_i;
	always_ff @(posedge clk_i)
	begin
		ph_valid_o <= fire_i & ~srst_i;
		fr_valid_o <= fire_i & ~srst_i;
		sgn_q <= srst_i ? 1'b0 : sgn_q ^ fire_i;
		// stale data is inverted between samples, never left looking valid
		ph_err_o <= fire_i ? val_d : ~ph_err_o;
		fr_diff_o <= fire_i ? val_d : ~fr_diff_o;
	end
endmodule

// File: test/dlc_top_tb.sv
// self-checking bench for the lock detect and loop control block
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t %h %h", $time, a, e); end end
module dlc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dlc_pkg::*;
	logic clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [31:0] lft = 32'h0;
	logic [3:0] refv = 4'hf;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdat, mag = 32'h0, tw;
	logic [1:0] rsp, sel = 2'h0;
	logic fire = 1'b0, lfv = 1'b0, awr, wr_o, bv, arr, rv, phv, frv, phl, frl;
	logic [1:0] br, rr, actr;
	logic [31:0] rd_o, phe, frd, tw_o;
	logic [4:0] st;
	int mismatches = 0, num_checks = 0, cyc = 0;
	always #2.5 clk = ~clk;
	dlc_top i_dlc_top (.CLK_SYS_I(clk), .SRST_I(srst), .S_AXI_AWADDR_I(awa),
		.S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
		.S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_o),
		.S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rd_o), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rry), .PH_VALID_I(phv), .PH_ERR_I(phe), .FR_VALID_I(frv),
		.FR_DIFF_I(frd), .LF_VALID_I(lfv), .LF_TW_I(lft), .REF_VALID_I(refv),
		.REF_SEL_I(sel), .TW_O(tw_o), .PH_LOCK_O(phl), .FR_LOCK_O(frl),
		.LOOP_STATE_O(st), .ACT_REF_O(actr));
	dlc_ref_model i_dlc_ref_model (.clk_i(clk), .srst_i(srst), .fire_i(fire), .mag_i(mag),
		.ph_valid_o(phv), .ph_err_o(phe), .fr_valid_o(frv), .fr_diff_o(frd));
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			close_out();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge clk);
		awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
		while (!done)
		begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr_o) wv <= 1'b0;
			if (bv)
			begin
				done = 1'b1;
				rsp = br;
			end
		end
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		ara <= a; arv <= 1'b1; rry <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		while (!rv) @(posedge clk);
		rdat = rd_o; rsp = rr;
		rry <= 1'b0;
	endtask
	task automatic smp(input int n, input logic [31:0] m);
		mag <= m;
		repeat (n)
		begin
			@(posedge clk) fire <= 1'b1;
			@(posedge clk) fire <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask
	task automatic lvl(input logic [31:0] e, input logic [1:0] lk);
		rd(OFS_LEVEL);
		`CHK(rdat, e)
		`CHK({frl, phl}, lk)
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (10) @(posedge clk);
		lvl(32'hf800_f800, 2'h0);
		rd(OFS_TW_MAX);
		`CHK(rdat, TW_MAX_RST)
		rd(8'h3c);
		`CHK(rsp, RESP_SLVERR)
		wr(8'h3c, 32'h1);
		`CHK(rsp, RESP_SLVERR)
		`CHK(st, ST_CLOSED)
		$display("reset test done");
		wr(OFS_PROF_BASE, 32'h64);
		wr(OFS_PROF_BASE + 8'h4, 32'h64);
		wr(OFS_PROF_BASE + 8'h8, 32'h4080_4080);
		`CHK(rsp, RESP_OKAY)
		// a new profile only takes effect once the loop has been broken
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CTRL, 32'h0);
		repeat (6) @(posedge clk);
		`CHK(st, ST_CLOSED)
		smp(24, 32'h64);
		lvl(32'h0400_0400, 2'h0);
		smp(1, 32'h64);
		lvl(32'h0480_0480, 2'h3);
		smp(10, 32'h0);
		lvl(32'h0800_0800, 2'h3);
		smp(40, 32'h65);
		lvl(32'hfe00_fe00, 2'h3);
		smp(9, 32'h65);
		lvl(32'hfbc0_fbc0, 2'h0);
		$display("bucket test done");
		smp(32, 32'h0);
		sel <= 2'h1;
		repeat (4)
		begin
			@(posedge clk);
			`CHK({frl, phl}, 2'h3)
		end
		`CHK(actr, 2'h1)
		`CHK(st, ST_CLOSED)
		rd(OFS_STATUS);
		`CHK(rdat, 32'h0000_0143)
		$display("switchover test done");
		wr(OFS_TW_MAX, 32'h200);
		wr(OFS_CTRL, 32'h10);
		lfv <= 1'b1;
		lft <= 32'h40;
		@(posedge clk);
		lft <= 32'h300;
		@(posedge clk);
		lfv <= 1'b0;
		@(posedge clk);
		`CHK(tw_o, 32'h200)
		rd(OFS_HOLD_TW);
		`CHK(rdat, 32'h1a0)
		$display("tuning word test done");
		wr(OFS_CTRL, 32'h1);
		repeat (4) @(posedge clk);
		tw = tw_o;
		`CHK(tw_o, 32'h1a0)
		`CHK(st, ST_HOLD)
		`CHK({frl, phl}, 2'h0)
		lfv <= 1'b1;
		lft <= 32'h150;
		repeat (8) @(posedge clk);
		lfv <= 1'b0;
		`CHK(tw_o, tw)
		`CHK(st, ST_HOLD)
		wr(OFS_CTRL, 32'h0);
		repeat (6) @(posedge clk);
		`CHK(st, ST_CLOSED)
		refv <= 4'hd;
		repeat (4) @(posedge clk);
		`CHK(st, ST_HOLD)
		refv <= 4'hf;
		repeat (6) @(posedge clk);
		`CHK(st, ST_CLOSED)
		$display("holdover test done");
		wr(OFS_TW_MIN, 32'h10);
		wr(OFS_FREERUN_TW, 32'h5);
		wr(OFS_CTRL, 32'h2);
		repeat (4) @(posedge clk);
		`CHK(st, ST_FREE)
		`CHK(tw_o, 32'h10)
		lvl(32'hf800_f800, 2'h0);
		$display("free run test done");
		close_out();
	end
endmodule
